// [core/lsi_lane_flags.sv]
`timescale 1ns/100ps
module lsi_lane_flags
  import lsi_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       resetn_i,
  // Lane conditions
  input  wire logic       sod_i,
  input  wire logic       soa_i,
  input  wire logic       cgs_i,
  input  wire logic       comma_i,
  input  wire logic       streaming_i,
  input  wire logic       clear_i,
  // Debug nibble
  output logic      [3:0] flags_o
);

  lsi_lane_state_t s_reg;
  lsi_lane_state_t s_next;

  // Start flags hold until a read; a read while streaming cannot clear them
  always_comb
  begin
    s_next     = s_reg;
    s_next.sod = ((s_reg.sod & (~clear_i | streaming_i)) | sod_i);
    s_next.soa = ((s_reg.soa & (~clear_i | streaming_i)) | soa_i);
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  // Sync and comma bits are live, the start bits are latched
  assign flags_o = {s_reg.sod, s_reg.soa, cgs_i, comma_i};

  property p_hold_streaming;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (s_reg.sod && clear_i && streaming_i) |=> s_reg.sod;
  endproperty
  a_hold_streaming: assert property (p_hold_streaming) else $error("start flag lost while streaming");

endmodule

// [core/lsi_pkg.sv]
package lsi_pkg;

  // Lane count and register port widths
  localparam int LSI_LANES = 8;
  localparam int LSI_AW    = 8;

  // Register byte offsets
  localparam logic [7:0] LSI_OFS_LANE_DEBUG  = 8'h00;
  localparam logic [7:0] LSI_OFS_LINK_STATUS = 8'h04;
  localparam logic [7:0] LSI_OFS_IRQ_ENABLE  = 8'h08;
  localparam logic [7:0] LSI_OFS_IRQ_TRIG    = 8'h0c;
  localparam logic [7:0] LSI_OFS_CFG0        = 8'h10;
  localparam logic [7:0] LSI_OFS_CFG1        = 8'h14;
  localparam logic [7:0] LSI_OFS_CFG2        = 8'h18;

  // Bit positions shared by status, enable and triggered registers
  localparam int LSI_B_ALIGN_ERR = 15;
  localparam int LSI_B_STARTED   = 14;
  localparam int LSI_B_RESYNC    = 13;
  localparam int LSI_B_CGS       = 13;
  localparam int LSI_B_SYNC      = 12;
  localparam int LSI_B_OVERFLOW  = 10;
  localparam int LSI_B_FEC       = 9;
  localparam int LSI_B_CRC       = 8;
  localparam int LSI_B_MB_ERR    = 7;
  localparam int LSI_B_BS_ERR    = 6;
  localparam int LSI_B_MB_LOCK   = 5;
  localparam int LSI_B_SH_LOCK   = 4;
  localparam int LSI_B_SREF_ERR  = 2;
  localparam int LSI_B_SREF_CAP  = 1;
  localparam int LSI_B_GLOBAL    = 0;

  // Writable field masks and reset values
  localparam logic [31:0] LSI_IRQ_EN_MASK   = 32'h0000_77f7;
  localparam logic [31:0] LSI_IRQ_SRC_MASK  = 32'h0000_77f6;
  localparam logic [31:0] LSI_CFG0_MASK     = 32'h0000_0fff;
  localparam logic [31:0] LSI_CFG1_MASK     = 32'h031f_1fff;
  localparam logic [31:0] LSI_CFG2_MASK     = 32'h1f01_1f00;
  localparam logic [31:0] LSI_REG_RESET     = 32'h0000_0000;

  // Consecutive misaligned framing characters that flag an alignment error
  localparam logic [3:0] LSI_MISALIGN_RUN = 4'h8;

  // Per-lane status from the alignment logic
  typedef struct packed {
    logic [7:0] sod;
    logic [7:0] soa;
    logic [7:0] cgs;
    logic [7:0] comma;
    logic [7:0] mb_lock;
    logic [7:0] sh_lock;
  } lsi_lane_t;

  // One-cycle event pulses from the link
  typedef struct packed {
    logic resync_req;
    logic overflow;
    logic fec_err;
    logic crc_err;
    logic mb_err;
    logic bs_err;
    logic sysref_err;
    logic sysref_cap;
  } lsi_evt_t;

  // Alignment configuration words
  typedef struct packed {
    logic [31:0] w0;
    logic [31:0] w1;
    logic [31:0] w2;
  } lsi_ila_t;

  // Per-lane latch state
  typedef struct packed {
    logic sod;
    logic soa;
  } lsi_lane_state_t;

  // Register bank state
  typedef struct packed {
    logic [31:0] irq_en;
    logic [31:0] irq_trig;
    lsi_ila_t    cfg;
    logic        align_err;
    logic        started;
    logic        overflow;
    logic        sref_err;
    logic        sref_cap;
    logic [3:0]  mis_cnt;
    logic        sync_q;
    logic        mb_any_q;
    logic        sh_any_q;
    logic        irq;
    logic [31:0] rdata;
    logic        ack;
  } lsi_state_t;

endpackage

// [core/lsi_regs.sv]
`timescale 1ns/100ps
module lsi_regs
  import lsi_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              resetn_i,
  // Register port
  input  wire logic [LSI_AW-1:0] reg_addr_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  input  wire logic [31:0]       reg_wdata_i,
  output logic      [31:0]       reg_rdata_o,
  output logic                   reg_ack_o,
  // Link status
  input  wire lsi_lane_t         lane_i,
  input  wire lsi_evt_t          evt_i,
  input  wire logic              streaming_i,
  input  wire logic              cgs_i,
  input  wire logic              sync_i,
  input  wire logic              frame_char_i,
  input  wire logic              frame_misaligned_i,
  // Alignment configuration
  input  wire logic              rx_mode_i,
  input  wire logic              ila_capture_i,
  input  wire lsi_ila_t          ila_rx_i,
  output lsi_ila_t               ila_cfg_o,
  // Interrupt
  output logic                   irq_o
);

  lsi_state_t s_reg;
  lsi_state_t s_next;

  logic [4*LSI_LANES-1:0] debug_w;
  logic [31:0]            status_w;
  logic [31:0]            event_w;
  logic                   mb_any;
  logic                   sh_any;
  logic                   rd_debug;
  logic                   rd_status;

  // Lock summaries over all lanes
  assign mb_any = |lane_i.mb_lock;
  assign sh_any = |lane_i.sh_lock;

  // Read strobes that carry a side effect
  assign rd_debug  = reg_rd_i && (reg_addr_i == LSI_OFS_LANE_DEBUG);
  assign rd_status = reg_rd_i && (reg_addr_i == LSI_OFS_LINK_STATUS);

  // One latch per lane for the debug nibble
  for (genvar g = 0; g < LSI_LANES; g++)
  begin : g_lane
    lsi_lane_flags u_flags (
      .clk_sys_i   (clk_sys_i),
      .resetn_i    (resetn_i),
      .sod_i       (lane_i.sod[g]),
      .soa_i       (lane_i.soa[g]),
      .cgs_i       (lane_i.cgs[g]),
      .comma_i     (lane_i.comma[g]),
      .streaming_i (streaming_i),
      .clear_i     (rd_debug),
      .flags_o     (debug_w[4*g +: 4])
    );
  end

  // Interrupt source events, one bit per source
  always_comb
  begin
    event_w                 = '0;
    event_w[LSI_B_STARTED]  = streaming_i & ~s_reg.started;
    event_w[LSI_B_RESYNC]   = evt_i.resync_req;
    event_w[LSI_B_SYNC]     = sync_i & ~s_reg.sync_q;
    event_w[LSI_B_OVERFLOW] = evt_i.overflow;
    event_w[LSI_B_FEC]      = evt_i.fec_err;
    event_w[LSI_B_CRC]      = evt_i.crc_err;
    event_w[LSI_B_MB_ERR]   = evt_i.mb_err;
    event_w[LSI_B_BS_ERR]   = evt_i.bs_err;
    event_w[LSI_B_MB_LOCK]  = s_reg.mb_any_q & ~mb_any;
    event_w[LSI_B_SH_LOCK]  = s_reg.sh_any_q & ~sh_any;
    event_w[LSI_B_SREF_ERR] = evt_i.sysref_err;
    event_w[LSI_B_SREF_CAP] = evt_i.sysref_cap;
  end

  // Link status word as software reads it
  always_comb
  begin
    status_w                 = '0;
    status_w[LSI_B_ALIGN_ERR] = s_reg.align_err;
    status_w[LSI_B_STARTED]  = s_reg.started;
    status_w[LSI_B_CGS]      = cgs_i;
    status_w[LSI_B_SYNC]     = sync_i;
    status_w[LSI_B_OVERFLOW] = s_reg.overflow;
    status_w[LSI_B_MB_LOCK]  = mb_any;
    status_w[LSI_B_SH_LOCK]  = sh_any;
    status_w[LSI_B_SREF_ERR] = s_reg.sref_err;
    status_w[LSI_B_SREF_CAP] = s_reg.sref_cap;
    status_w[LSI_B_GLOBAL]   = s_reg.irq;
  end

  // Next-state logic; in every sticky bit a new event beats a clear
  always_comb
  begin
    s_next          = s_reg;
    s_next.ack      = reg_rd_i | reg_wr_i;
    s_next.sync_q   = sync_i;
    s_next.mb_any_q = mb_any;
    s_next.sh_any_q = sh_any;

    // Misaligned run counter saturates at the run length
    if (frame_char_i && frame_misaligned_i)
      s_next.mis_cnt = (s_reg.mis_cnt == LSI_MISALIGN_RUN) ? LSI_MISALIGN_RUN : s_reg.mis_cnt + 4'h1;
    else if (frame_char_i)
      s_next.mis_cnt = 4'h0;
    // Only a new misaligned character sets it again, so a read clears the flag but leaves a saturated run counter at eight
    s_next.align_err = (s_reg.align_err & ~rd_status) |
                       (frame_char_i & frame_misaligned_i & (s_next.mis_cnt == LSI_MISALIGN_RUN));

    // Started holds until sync drops, so a resync can report a new start
    s_next.started  = (s_reg.started & sync_i) | streaming_i;
    s_next.overflow = (s_reg.overflow & ~rd_status) | evt_i.overflow;
    s_next.sref_err = (s_reg.sref_err & ~rd_status) | evt_i.sysref_err;
    s_next.sref_cap = (s_reg.sref_cap & ~rd_status) | evt_i.sysref_cap;

    // Interrupt enables
    if (reg_wr_i && (reg_addr_i == LSI_OFS_IRQ_ENABLE))
      s_next.irq_en = reg_wdata_i & LSI_IRQ_EN_MASK;

    // Triggered flags: write one to clear, enabled event sets
    s_next.irq_trig = s_reg.irq_trig;
    if (reg_wr_i && (reg_addr_i == LSI_OFS_IRQ_TRIG))
      s_next.irq_trig = s_reg.irq_trig & ~reg_wdata_i;
    s_next.irq_trig = s_next.irq_trig | (event_w & s_reg.irq_en & LSI_IRQ_SRC_MASK);

    // Output needs both a live enabled source and the global enable
    s_next.irq = s_next.irq_en[LSI_B_GLOBAL] &
                 (|(s_next.irq_trig & s_next.irq_en & LSI_IRQ_SRC_MASK));

    // Configuration words; a receiver capture overrides a software write
    if (reg_wr_i && (reg_addr_i == LSI_OFS_CFG0))
      s_next.cfg.w0 = reg_wdata_i & LSI_CFG0_MASK;
    if (reg_wr_i && (reg_addr_i == LSI_OFS_CFG1))
      s_next.cfg.w1 = reg_wdata_i & LSI_CFG1_MASK;
    if (reg_wr_i && (reg_addr_i == LSI_OFS_CFG2))
      s_next.cfg.w2 = reg_wdata_i & LSI_CFG2_MASK;
    if (rx_mode_i && ila_capture_i)
    begin
      s_next.cfg.w0 = ila_rx_i.w0 & LSI_CFG0_MASK;
      s_next.cfg.w1 = ila_rx_i.w1 & LSI_CFG1_MASK;
      s_next.cfg.w2 = ila_rx_i.w2 & LSI_CFG2_MASK;
    end

    // Read data, unmapped offsets return zero
    s_next.rdata = '0;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        LSI_OFS_LANE_DEBUG:  s_next.rdata = debug_w;
        LSI_OFS_LINK_STATUS: s_next.rdata = status_w;
        LSI_OFS_IRQ_ENABLE:  s_next.rdata = s_reg.irq_en;
        LSI_OFS_IRQ_TRIG:    s_next.rdata = s_reg.irq_trig;
        LSI_OFS_CFG0:        s_next.rdata = s_reg.cfg.w0;
        LSI_OFS_CFG1:        s_next.rdata = s_reg.cfg.w1;
        LSI_OFS_CFG2:        s_next.rdata = s_reg.cfg.w2;
        default:             s_next.rdata = '0;
      endcase
    end
  end

  // State register, every field cleared by reset
  always_ff @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      s_reg          <= '0;
      s_reg.irq_en   <= LSI_REG_RESET;
      s_reg.cfg      <= '0;
    end
    else
      s_reg <= s_next;
  end

  // Outputs straight from flip-flops; in transmit mode the link sends these words
  assign reg_rdata_o = s_reg.rdata;
  assign reg_ack_o   = s_reg.ack;
  assign ila_cfg_o   = s_reg.cfg;
  assign irq_o       = s_reg.irq;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  property p_global_gate;
    irq_o |-> s_reg.irq_en[LSI_B_GLOBAL];
  endproperty
  a_global_gate: assert property (p_global_gate) else $error("interrupt without global enable");

  property p_en_reset;
    $rose(resetn_i) |-> (s_reg.irq_en == 32'h0000_0000) && (s_reg.cfg == '0) && !irq_o;
  endproperty
  a_en_reset: assert property (@(posedge clk_sys_i) p_en_reset) else $error("enables not zero after reset");

  property p_overflow_trig;
    (evt_i.overflow && s_reg.irq_en[LSI_B_OVERFLOW]) |=> s_reg.irq_trig[LSI_B_OVERFLOW] && s_reg.overflow;
  endproperty
  a_overflow_trig: assert property (p_overflow_trig) else $error("overflow not latched");

  property p_mb_loss;
    ($fell(mb_any) && s_reg.irq_en[LSI_B_MB_LOCK]) |=> s_reg.irq_trig[LSI_B_MB_LOCK];
  endproperty
  a_mb_loss: assert property (p_mb_loss) else $error("lock loss not triggered");

  property p_sync_rise;
    ($rose(sync_i) && s_reg.irq_en[LSI_B_SYNC]) |=> s_reg.irq_trig[LSI_B_SYNC];
  endproperty
  a_sync_rise: assert property (p_sync_rise) else $error("sync assertion not triggered");

  property p_fec_trig;
    (evt_i.fec_err && !s_reg.irq_en[LSI_B_FEC] && !s_reg.irq_trig[LSI_B_FEC]) |=> !s_reg.irq_trig[LSI_B_FEC];
  endproperty
  a_fec_trig: assert property (p_fec_trig) else $error("disabled source triggered");

  // Framing characters may be spread out, so the run is judged through the counter
  property p_align;
    (frame_char_i && frame_misaligned_i && (s_reg.mis_cnt == LSI_MISALIGN_RUN - 4'h1)) |=> s_reg.align_err;
  endproperty
  a_align: assert property (p_align) else $error("alignment error not set");

  property p_run_count;
    (frame_char_i && frame_misaligned_i && (s_reg.mis_cnt != LSI_MISALIGN_RUN))
      |=> (s_reg.mis_cnt == $past(s_reg.mis_cnt) + 4'h1);
  endproperty
  a_run_count: assert property (p_run_count) else $error("misaligned run not counted");

  property p_run_reset;
    (frame_char_i && !frame_misaligned_i) |=> (s_reg.mis_cnt == 4'h0);
  endproperty
  a_run_reset: assert property (p_run_reset) else $error("aligned character kept the run");

  property p_align_clear;
    (rd_status && !(frame_char_i && frame_misaligned_i)) |=> !s_reg.align_err;
  endproperty
  a_align_clear: assert property (p_align_clear) else $error("alignment error not cleared by read");

  property p_lock_read;
    rd_status |=> (reg_rdata_o[LSI_B_MB_LOCK] == $past(mb_any)) && reg_ack_o;
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock summary read wrong");

  property p_cfg1_write;
    (reg_wr_i && reg_addr_i == LSI_OFS_CFG1 && !(rx_mode_i && ila_capture_i))
      |=> s_reg.cfg.w1 == ($past(reg_wdata_i) & LSI_CFG1_MASK);
  endproperty
  a_cfg1_write: assert property (p_cfg1_write) else $error("config word 1 not stored");

  property p_pending;
    (s_reg.irq_en[LSI_B_GLOBAL] && |(s_reg.irq_trig & s_reg.irq_en & LSI_IRQ_SRC_MASK)) |-> irq_o && status_w[0];
  endproperty
  a_pending: assert property (p_pending) else $error("pending interrupt not shown");

  // Register port side effects and the started flag set by streaming
  property p_w1c;
    (reg_wr_i && (reg_addr_i == LSI_OFS_IRQ_TRIG) && reg_wdata_i[LSI_B_OVERFLOW] && !evt_i.overflow)
      |=> !s_reg.irq_trig[LSI_B_OVERFLOW];
  endproperty
  a_w1c: assert property (p_w1c) else $error("triggered flag not cleared by write");

  property p_en_write;
    (reg_wr_i && (reg_addr_i == LSI_OFS_IRQ_ENABLE)) |=> (s_reg.irq_en == ($past(reg_wdata_i) & LSI_IRQ_EN_MASK));
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable word not stored");

  property p_sticky_clear;
    (rd_status && !evt_i.overflow) |=> !s_reg.overflow;
  endproperty
  a_sticky_clear: assert property (p_sticky_clear) else $error("overflow not cleared by read");

  property p_started;
    streaming_i |=> s_reg.started;
  endproperty
  a_started: assert property (p_started) else $error("receive started not set");

  c_irq: cover property ($rose(irq_o));
  c_align: cover property ($rose(s_reg.align_err));
  c_capture: cover property (rx_mode_i && ila_capture_i);
  c_clear: cover property (reg_wr_i && reg_addr_i == LSI_OFS_IRQ_TRIG && |s_reg.irq_trig);

endmodule

// [test/lsi_link_model.sv]
`timescale 1ns/100ps
module lsi_link_model
  import lsi_pkg::*;
(
  // Clock
  input  wire logic clk_sys_i,
  // Link conditions toward the register bank
  output lsi_lane_t lane_o,
  output lsi_evt_t  evt_o,
  output logic      streaming_o,
  output logic      cgs_o,
  output logic      sync_o,
  output logic      frame_char_o,
  output logic      frame_mis_o,
  output logic      capture_o,
  output lsi_ila_t  ila_o
);
  // Quiet link at time zero
  initial
  begin
    lane_o = '0;
    evt_o = '0;
    ila_o = '0;
    {streaming_o, cgs_o, sync_o, frame_char_o, frame_mis_o, capture_o} = '0;
  end

  // Levels change just after an edge and hold until the next call
  task automatic set_levels(input lsi_lane_t l, input logic s, input logic c, input logic y);
    @(posedge clk_sys_i);
    lane_o      <= l;
    streaming_o <= s;
    cgs_o       <= c;
    sync_o      <= y;
  endtask

  // Link events last exactly one cycle
  task automatic pulse(input lsi_evt_t e);
    @(posedge clk_sys_i);
    evt_o <= e;
    @(posedge clk_sys_i);
    evt_o <= '0;
  endtask

  // The qualifier is meaningless outside a framing character, so it flips there
  task automatic frame(input logic mis);
    @(posedge clk_sys_i);
    frame_char_o <= 1'b1;
    frame_mis_o  <= mis;
    @(posedge clk_sys_i);
    frame_char_o <= 1'b0;
    frame_mis_o  <= ~mis;
  endtask

  // Captured words are only valid with the strobe; garbage afterwards
  task automatic capture(input lsi_ila_t w);
    @(posedge clk_sys_i);
    ila_o     <= w;
    capture_o <= 1'b1;
    @(posedge clk_sys_i);
    capture_o <= 1'b0;
    ila_o     <= ~w;
  endtask
endmodule

// [test/testbench.sv]
`timescale 1ns/100ps
module testbench;
  import lsi_pkg::*;
  logic              clk_sys_i;
  logic              resetn_i;
  logic [LSI_AW-1:0] reg_addr_i;
  logic              reg_wr_i;
  logic              reg_rd_i;
  logic [31:0]       reg_wdata_i;
  logic [31:0]       reg_rdata_o;
  logic              reg_ack_o;
  lsi_lane_t         lane;
  lsi_evt_t          evt;
  logic              streaming, cgs, sync, fch, fmis, cap, rx_mode_i, irq_o;
  lsi_ila_t          ila_rx;
  lsi_ila_t          ila_cfg_o;
  int                err_count = 0;
  int                n_compared = 0;

  lsi_regs uut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o),
    .lane_i(lane), .evt_i(evt), .streaming_i(streaming), .cgs_i(cgs), .sync_i(sync), .frame_char_i(fch),
    .frame_misaligned_i(fmis), .rx_mode_i(rx_mode_i), .ila_capture_i(cap), .ila_rx_i(ila_rx),
    .ila_cfg_o(ila_cfg_o), .irq_o(irq_o));
  lsi_link_model link (.clk_sys_i(clk_sys_i), .lane_o(lane), .evt_o(evt), .streaming_o(streaming),
    .cgs_o(cgs), .sync_o(sync), .frame_char_o(fch), .frame_mis_o(fmis), .capture_o(cap), .ila_o(ila_rx));

  // 20 MHz clock
  initial
  begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check_word(input string name, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", name, e, g);
      err_count++;
    end
  endtask

  task automatic check_bit(input string name, input logic e, input logic g);
    n_compared++;
    if (g !== e)
    begin
      $display("wrong value %s expected %b seen %b", name, e, g);
      err_count++;
    end
  endtask

  // One strobe per access; the answer always comes exactly one cycle later
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= wr;
    reg_rd_i    <= ~wr;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    #1;
    check_bit("ack", 1'b1, reg_ack_o);
    q = reg_rdata_o;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, q);
    check_word($sformatf("reg %h", a), e, q);
  endtask

  task automatic t_reset;
    for (int a = 0; a <= 'h1c; a += 4)
      rd(8'(a), 32'h0);
    check_bit("irq", 1'b0, irq_o);
  endtask

  // Software words go out masked; a capture only lands in receive mode
  task automatic t_config;
    lsi_ila_t w;
    wr(LSI_OFS_LINK_STATUS, 32'hffff_ffff);
    for (int i = 0; i < 3; i++)
      wr(LSI_OFS_CFG0 + 8'(4 * i), 32'hffff_ffff);
    rd(LSI_OFS_LINK_STATUS, 32'h0);
    rd(LSI_OFS_CFG0, LSI_CFG0_MASK);
    rd(LSI_OFS_CFG1, LSI_CFG1_MASK);
    rd(LSI_OFS_CFG2, LSI_CFG2_MASK);
    check_word("cfg out0", LSI_CFG0_MASK, ila_cfg_o.w0);
    check_word("cfg out1", LSI_CFG1_MASK, ila_cfg_o.w1);
    check_word("cfg out2", LSI_CFG2_MASK, ila_cfg_o.w2);
    w = '{32'h0000_0a5c, 32'h0213_0c3f, 32'h1501_0700};
    @(posedge clk_sys_i);
    rx_mode_i <= 1'b1;
    link.capture(w);
    rd(LSI_OFS_CFG0, w.w0);
    rd(LSI_OFS_CFG1, w.w1);
    rd(LSI_OFS_CFG2, w.w2);
    @(posedge clk_sys_i);
    rx_mode_i <= 1'b0;
    link.capture(~w);
    rd(LSI_OFS_CFG0, w.w0);
    check_word("cfg out2", w.w2, ila_cfg_o.w2);
  endtask

  task automatic t_lane;
    lsi_lane_t l;
    l = '0;
    l.cgs[5] = 1'b1;
    l.comma[5] = 1'b1;
    l.sod[3] = 1'b1;
    l.soa[0] = 1'b1;
    link.set_levels(l, 1'b0, 1'b0, 1'b0);
    l.sod = '0;
    l.soa = '0;
    link.set_levels(l, 1'b0, 1'b0, 1'b0);
    rd(LSI_OFS_LANE_DEBUG, 32'h0030_8004);
    rd(LSI_OFS_LANE_DEBUG, 32'h0030_0000);
    l.sod[1] = 1'b1;
    link.set_levels(l, 1'b1, 1'b0, 1'b0);
    l.sod = '0;
    link.set_levels(l, 1'b1, 1'b0, 1'b0);
    rd(LSI_OFS_LANE_DEBUG, 32'h0030_0080);
    rd(LSI_OFS_LANE_DEBUG, 32'h0030_0080);
    link.set_levels('0, 1'b0, 1'b0, 1'b0);
    rd(LSI_OFS_LINK_STATUS, 32'h0);
  endtask

  // An aligned character in the middle restarts the run of eight
  task automatic t_align;
    repeat (7) link.frame(1'b1);
    link.frame(1'b0);
    repeat (7) link.frame(1'b1);
    rd(LSI_OFS_LINK_STATUS, 32'h0);
    link.frame(1'b1);
    rd(LSI_OFS_LINK_STATUS, 32'h0000_8000);
    rd(LSI_OFS_LINK_STATUS, 32'h0);
  endtask

  // Events with every enable clear must not trigger anything
  task automatic t_status;
    lsi_lane_t l;
    link.pulse('{overflow: 1'b1, fec_err: 1'b1, sysref_err: 1'b1, sysref_cap: 1'b1, default: 1'b0});
    rd(LSI_OFS_LINK_STATUS, 32'h0000_0406);
    rd(LSI_OFS_LINK_STATUS, 32'h0);
    rd(LSI_OFS_IRQ_TRIG, 32'h0);
    l = '0;
    l.mb_lock[2] = 1'b1;
    l.sh_lock[7] = 1'b1;
    link.set_levels(l, 1'b1, 1'b1, 1'b1);
    rd(LSI_OFS_LINK_STATUS, 32'h0000_7030);
    link.set_levels('0, 1'b0, 1'b0, 1'b0);
    rd(LSI_OFS_LINK_STATUS, 32'h0);
  endtask

  // Every source fires with its enable set but the global enable clear
  task automatic t_irq;
    logic [31:0] q;
    wr(LSI_OFS_IRQ_ENABLE, 32'hffff_fff6);
    rd(LSI_OFS_IRQ_ENABLE, 32'h0000_77f6);
    link.set_levels('0, 1'b0, 1'b0, 1'b1);
    link.set_levels('1, 1'b1, 1'b0, 1'b1);
    link.set_levels('0, 1'b1, 1'b0, 1'b1);
    link.pulse('1);
    rd(LSI_OFS_IRQ_TRIG, 32'h0000_77f6);
    check_bit("irq", 1'b0, irq_o);
    rd(LSI_OFS_LINK_STATUS, 32'h0000_5406);
    wr(LSI_OFS_IRQ_ENABLE, 32'h0000_77f7);
    check_bit("irq", 1'b1, irq_o);
    rd(LSI_OFS_LINK_STATUS, 32'h0000_5001);
    wr(LSI_OFS_IRQ_TRIG, 32'h0000_0400);
    rd(LSI_OFS_IRQ_TRIG, 32'h0000_73f6);
    wr(LSI_OFS_IRQ_TRIG, 32'hffff_ffff);
    rd(LSI_OFS_IRQ_TRIG, 32'h0);
    check_bit("irq", 1'b0, irq_o);
    wr(LSI_OFS_IRQ_ENABLE, 32'h0000_0401);
    link.pulse('{overflow: 1'b1, default: 1'b0});
    // The pulse returns on the edge that raises the output, so let it settle
    #1;
    check_bit("irq", 1'b1, irq_o);
    wr(LSI_OFS_IRQ_ENABLE, 32'h0000_0400);
    check_bit("irq", 1'b0, irq_o);
    acc(1'b0, LSI_OFS_IRQ_TRIG, 32'h0, q);
    check_word("trig", 32'h0000_0400, q);
  endtask

  // Reset in mid-run drops latched lane flags, enables, triggers and config
  task automatic t_midreset;
    lsi_lane_t l;
    l = '0;
    l.sod[6] = 1'b1;
    link.set_levels(l, 1'b0, 1'b0, 1'b0);
    link.set_levels('0, 1'b0, 1'b0, 1'b0);
    @(posedge clk_sys_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    rd(LSI_OFS_LANE_DEBUG, 32'h0);
    rd(LSI_OFS_IRQ_ENABLE, 32'h0);
    rd(LSI_OFS_IRQ_TRIG, 32'h0);
    rd(LSI_OFS_CFG0, 32'h0);
    check_bit("irq", 1'b0, irq_o);
  endtask

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    err_count++;
    complete_run;
  end

  initial
  begin
    resetn_i = 1'b0;
    reg_addr_i = '0;
    reg_wdata_i = '0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    rx_mode_i = 1'b0;
    repeat (5) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    t_reset;
    t_config;
    t_lane;
    t_align;
    t_status;
    t_irq;
    t_midreset;
    complete_run;
  end
endmodule
